// *** hdl/port_expander_core.sv ***
// Purpose: Address decode, power-up defaults and change detect of the port expander
// Assumes: Bus clock is a second clock domain; system clock much faster than a byte
// Notes: Transmit word is frozen in the system domain while a frame is open
`timescale 1ns/10ps
`include "port_map.svh"
module port_expander_core import port_pkg::*; #(
   parameter int SETTLE = `SETTLE_CYC
) (
   input wire logic clk_sys,           // System clock, 10 MHz
   input wire logic nrst,              // Async reset, active low
   input wire logic scl_i,             // Bus clock, link domain clock
   input wire logic sda_i,             // Bus data level
   output logic sda_o_q,               // Bus data drive value, always low
   output logic sda_oe_n_q,            // Bus data enable, low drives
   input wire logic addr_sel_low,      // Lower address pin level
   input wire logic addr_sel_high,     // Upper address pin level
   input wire logic [7:0] bidir_ports_i,   // Bidirectional port levels
   output logic [7:0] bidir_ports_o_q,     // Drive value, always low
   output logic [7:0] bidir_ports_oe_n_q,  // Low pulls the port down
   output logic [7:0] pullup_en_q,         // Input pullup enables
   output logic [7:0] pushpull_outputs_q,  // Push-pull output levels
   output logic alert_n_q                  // Change alert, active low
);
   if (SETTLE < 3 || SETTLE > 15) begin : g_bad
      $error("SETTLE must cover the pin synchroniser, 3 to 15");
   end

   // Link domain state
   logic start_tgl_q, stop_tgl_q, start_ack_q;
   link_st_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, wdata_q;
   logic grp_pp_q, byte_sel_q, access_tgl_q, wr_tgl_q, acc_rd_q;
   logic cls_valid_q, gnd_hi_q, gnd_lo_q;
   logic [1:0] pos0_q, mis_q, neg0_q, pin_neg_q;
   // System domain state
   logic [7:0] snap_q, flags_q, hold_lv_q, hold_fl_q, hold_pp_q;
   logic [3:0] tg_prev_q, mask_cnt_q;
   logic busy_q, rd_hold_q, init_done_q, resnap_q;
   logic [1:0] init_cnt_q, gnd_q;
   logic [7:0] xs, live;
   logic [9:0] ps;
   logic evt_start, evt_stop, evt_acc, evt_wr, new_start;
   conn_t cls_hi_now, cls_lo_now;
   logic hit_bidir, hit_pp, drive0;
   logic [7:0] tx_byte;

   function automatic conn_t classify(input logic p0, input logic mis, input logic n0);
      if (p0 && !mis) return CONN_SDA;
      else if (p0) return CONN_GND;
      else if (n0) return CONN_SCL;
      else return CONN_VDD;
   endfunction
   function automatic logic [1:0] hi_bits(input conn_t c);
      case (c)
         CONN_SCL: return `HI_SCL;
         CONN_SDA: return `HI_SDA;
         CONN_GND: return `HI_GND;
         default: return `HI_VDD;
      endcase
   endfunction
   function automatic logic [1:0] lo_bits(input conn_t c);
      case (c)
         CONN_GND: return `LO_GND;
         CONN_VDD: return `LO_VDD;
         CONN_SCL: return `LO_SCL;
         default: return `LO_SDA;
      endcase
   endfunction

   // Start and stop seen on data edges while clock high
   always_ff @(negedge sda_i or negedge nrst) begin
      if (!nrst) start_tgl_q <= 1'h0;
      else if (scl_i) start_tgl_q <= ~start_tgl_q;
   end
   always_ff @(posedge sda_i or negedge nrst) begin
      if (!nrst) stop_tgl_q <= 1'h0;
      else if (scl_i) stop_tgl_q <= ~stop_tgl_q;
   end

   // Address decode from pin classes of this frame
   assign new_start = start_tgl_q ^ start_ack_q;
   assign cls_hi_now = classify(pos0_q[1], mis_q[1], neg0_q[1]);
   assign cls_lo_now = classify(pos0_q[0], mis_q[0], neg0_q[0]);
   assign hit_bidir = sh_q[7:5] == `ADDR_TOP_BIDIR &&
      sh_q[4:1] == {hi_bits(cls_hi_now), lo_bits(cls_lo_now)};
   assign hit_pp = sh_q[7:5] == `ADDR_TOP_PUSH &&
      sh_q[4:1] == {hi_bits(cls_hi_now), lo_bits(cls_lo_now)};
   assign tx_byte = grp_pp_q ? hold_pp_q : (byte_sel_q ? hold_fl_q : hold_lv_q);

   // Link shift engine on rising bus clock
   always_ff @(posedge scl_i or negedge nrst) begin
      if (!nrst) begin
         start_ack_q <= 1'h0;
         st_q <= S_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         pos0_q <= 2'h0;
         mis_q <= 2'h0;
         neg0_q <= 2'h0;
      end else if (new_start) begin
         start_ack_q <= start_tgl_q;
         st_q <= S_ADDR;
         cnt_q <= 4'h1;
         sh_q <= {7'h00, sda_i};
         pos0_q <= {~addr_sel_high, ~addr_sel_low};
         mis_q <= {addr_sel_high ^ sda_i, addr_sel_low ^ sda_i};
         neg0_q <= ~pin_neg_q;
      end else begin
         case (st_q)
            S_ADDR: begin
               if (cnt_q < 4'h8) begin
                  sh_q <= {sh_q[6:0], sda_i};
                  cnt_q <= cnt_q + 4'h1;
                  pos0_q <= pos0_q | {~addr_sel_high, ~addr_sel_low};
                  mis_q <= mis_q | {addr_sel_high ^ sda_i, addr_sel_low ^ sda_i};
                  neg0_q <= neg0_q | ~pin_neg_q;
               end else if (hit_bidir || hit_pp) begin
                  st_q <= sh_q[0] ? S_RD : S_WR;
                  cnt_q <= 4'h0;
               end else begin
                  st_q <= S_IDLE;
               end
            end
            S_WR: begin
               sh_q <= (cnt_q < 4'h8) ? {sh_q[6:0], sda_i} : sh_q;
               cnt_q <= (cnt_q < 4'h8) ? cnt_q + 4'h1 : 4'h0;
            end
            S_RD: begin
               if (cnt_q < 4'h8) cnt_q <= cnt_q + 4'h1;
               else if (sda_i) st_q <= S_IDLE;
               else cnt_q <= 4'h0;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // Frame results handed to the system domain
   always_ff @(posedge scl_i or negedge nrst) begin
      if (!nrst) begin
         access_tgl_q <= 1'h0;
         wr_tgl_q <= 1'h0;
         wdata_q <= 8'h00;
         grp_pp_q <= 1'h0;
         acc_rd_q <= 1'h0;
         byte_sel_q <= 1'h0;
         cls_valid_q <= 1'h0;
         gnd_hi_q <= 1'h0;
         gnd_lo_q <= 1'h0;
      end else if (!new_start && cnt_q == 4'h8) begin
         if (st_q == S_ADDR) begin
            cls_valid_q <= 1'h1;
            gnd_hi_q <= cls_hi_now == CONN_GND;
            gnd_lo_q <= cls_lo_now == CONN_GND;
            byte_sel_q <= 1'h0;
            if (hit_bidir || hit_pp) begin
               access_tgl_q <= ~access_tgl_q;
               grp_pp_q <= hit_pp;
               acc_rd_q <= sh_q[0];
            end
         end else if (st_q == S_WR) begin
            wdata_q <= sh_q;
            wr_tgl_q <= ~wr_tgl_q;
         end else if (st_q == S_RD && !grp_pp_q) begin
            byte_sel_q <= ~byte_sel_q;
         end
      end
   end

   // Data line driven on falling bus clock
   assign drive0 = !new_start && ((st_q == S_ADDR && cnt_q == 4'h8 && (hit_bidir || hit_pp)) ||
      (st_q == S_WR && cnt_q == 4'h8) ||
      (st_q == S_RD && cnt_q < 4'h8 && !tx_byte[~cnt_q[2:0]]));
   always_ff @(negedge scl_i or negedge nrst) begin
      if (!nrst) begin
         sda_oe_n_q <= 1'h1;
         sda_o_q <= 1'h0;
         pin_neg_q <= 2'h3;
      end else begin
         sda_oe_n_q <= ~drive0;
         sda_o_q <= 1'h0;
         pin_neg_q <= {addr_sel_high, addr_sel_low};
      end
   end

   // Crossings into the system domain
   sync_2ff #(.WIDTH(8)) u_sync_ev (
      .clk(clk_sys),
      .nrst(nrst),
      .d({start_tgl_q, stop_tgl_q, access_tgl_q, wr_tgl_q, acc_rd_q, cls_valid_q,
          gnd_hi_q, gnd_lo_q}),
      .q(xs)
   );
   sync_2ff #(.WIDTH(10)) u_sync_pin (
      .clk(clk_sys),
      .nrst(nrst),
      .d({addr_sel_high, addr_sel_low, bidir_ports_i}),
      .q(ps)
   );
   assign live = ps[7:0];
   assign evt_start = xs[7] ^ tg_prev_q[3];
   assign evt_stop = xs[6] ^ tg_prev_q[2];
   assign evt_acc = xs[5] ^ tg_prev_q[1];
   assign evt_wr = xs[4] ^ tg_prev_q[0];

   // Toggle edges, frame busy and read hold
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tg_prev_q <= 4'h0;
         busy_q <= 1'h0;
         rd_hold_q <= 1'h0;
      end else begin
         tg_prev_q <= xs[7:4];
         busy_q <= evt_start | (busy_q & ~evt_stop);
         rd_hold_q <= (evt_acc & xs[3]) | (rd_hold_q & ~evt_stop & ~evt_start);
      end
   end

   // Strap capture after reset, then pin classes from each frame
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         init_cnt_q <= 2'h0;
         init_done_q <= 1'h0;
         gnd_q <= 2'h0;
      end else if (!init_done_q) begin
         init_cnt_q <= init_cnt_q + 2'h1;
         init_done_q <= init_cnt_q == `INIT_CYC;
         gnd_q <= ~ps[9:8];
      end else if (xs[2]) begin
         gnd_q <= xs[1:0];
      end
   end

   // Pullups and port latches
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pullup_en_q <= 8'h00;
         bidir_ports_oe_n_q <= 8'hff;
         bidir_ports_o_q <= 8'h00;
         pushpull_outputs_q <= 8'h00;
      end else begin
         pullup_en_q <= {{4{~gnd_q[1]}}, {4{~gnd_q[0]}}};
         bidir_ports_o_q <= 8'h00;
         if (!init_done_q) begin
            bidir_ports_oe_n_q <= {{4{ps[9]}}, {4{ps[8]}}};
            pushpull_outputs_q <= {{4{ps[9]}}, {4{ps[8]}}};
         end else if (evt_wr && !grp_pp_q) begin
            bidir_ports_oe_n_q <= wdata_q;
         end else if (evt_wr) begin
            pushpull_outputs_q <= wdata_q;
         end
      end
   end

   // Settle window after a bidirectional write, then resnapshot
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mask_cnt_q <= 4'h0;
         resnap_q <= 1'h0;
      end else begin
         if ((evt_wr && !grp_pp_q) || !init_done_q) mask_cnt_q <= 4'(SETTLE);
         else if (mask_cnt_q != 4'h0) mask_cnt_q <= mask_cnt_q - 4'h1;
         resnap_q <= mask_cnt_q == 4'h1;
      end
   end

   // Snapshot, sticky flags and alert
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         snap_q <= 8'h00;
         flags_q <= `FLAGS_RST;
         alert_n_q <= `ALERT_RST;
      end else begin
         if (evt_acc || resnap_q) snap_q <= live;
         if (evt_acc || resnap_q) flags_q <= `FLAGS_RST;
         else if (mask_cnt_q == 4'h0) flags_q <= flags_q | (live ^ snap_q);
         alert_n_q <= ~(|flags_q) | rd_hold_q;
      end
   end

   // Transmit word frozen while a frame is open
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hold_lv_q <= 8'h00;
         hold_fl_q <= 8'h00;
         hold_pp_q <= 8'h00;
      end else if (!busy_q && !evt_start) begin
         hold_lv_q <= live;
         hold_fl_q <= flags_q;
         hold_pp_q <= pushpull_outputs_q;
      end
   end

   // Checks
   sequence s_bidir_write;
      evt_wr && !grp_pp_q;
   endsequence
   sequence s_settle_done;
      ##[1:16] resnap_q;
   endsequence
   property p_alert_low;
      @(posedge clk_sys) disable iff (!nrst) (flags_q != 8'h00 && !rd_hold_q) |=> !alert_n_q;
   endproperty
   a_alert_low: assert property (p_alert_low) else $error("alert not asserted");
   property p_snap_take;
      @(posedge clk_sys) disable iff (!nrst) evt_acc |=> snap_q == $past(live);
   endproperty
   a_snap_take: assert property (p_snap_take) else $error("snapshot not taken");
   property p_release;
      @(posedge clk_sys) disable iff (!nrst) evt_acc ##1 !evt_wr |=> alert_n_q;
   endproperty
   a_release: assert property (p_release) else $error("alert not released");
   property p_sticky;
      @(posedge clk_sys) disable iff (!nrst)
         !evt_acc && !resnap_q |=> (flags_q & $past(flags_q)) == $past(flags_q);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_detect;
      @(posedge clk_sys) disable iff (!nrst)
         mask_cnt_q == 4'h0 && !evt_acc && !resnap_q && live != snap_q |=> flags_q != 8'h00;
   endproperty
   a_detect: assert property (p_detect) else $error("change missed");
   property p_pullup;
      @(posedge clk_sys) disable iff (!nrst)
         init_done_q |=> pullup_en_q == {{4{~$past(gnd_q[1])}}, {4{~$past(gnd_q[0])}}};
   endproperty
   a_pullup: assert property (p_pullup) else $error("pullup mismatch");
   property p_write_quiet;
      @(posedge clk_sys) disable iff (!nrst) s_bidir_write |=> s_settle_done;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("no resnapshot");
   property p_nomatch;
      @(posedge scl_i) disable iff (!nrst)
         !new_start && st_q == S_ADDR && cnt_q == 4'h8 && !hit_bidir && !hit_pp |=> st_q == S_IDLE;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("foreign address taken");
endmodule

// *** hdl/port_map.svh ***
// Purpose: Constants for the port expander address, change detect and power-up logic
// Assumes: Included by the core design file by bare name
// Notes: Functional notes follow
// Functional notes
// - Answer two 7-bit addresses, upper bits 110 and 101, low bits from pins.
// - Pullups on each nibble enabled unless that nibble's address pin is grounded.
// - Watch every bidirectional input for change against the last access snapshot.
// - Keep captured port levels in a snapshot register as change reference.
// - Any live input differing from snapshot drives alert low until next access.
// - At address acknowledge of each access, take snapshot and clear old flags.
// - Second byte of a bidirectional read carries the previously held change flags.
// - Power-up nibble levels high unless that nibble's address pin is grounded.
// - Change alert is released when the device is next accessed.
// - Port level changes caused by bus writes never raise the alert.
// - Address pin connections re-evaluated on every transmission, any target.
`ifndef PORT_MAP_SVH
`define PORT_MAP_SVH
`define ADDR_TOP_BIDIR 3'h6
`define ADDR_TOP_PUSH 3'h5
`define NPORTS 8
`define SETTLE_CYC 3
`define INIT_CYC 2'h2
`define ALERT_RST 1'h1
`define FLAGS_RST 8'h00
`define HI_SCL 2'h0
`define HI_SDA 2'h1
`define HI_GND 2'h2
`define HI_VDD 2'h3
`define LO_GND 2'h0
`define LO_VDD 2'h1
`define LO_SCL 2'h2
`define LO_SDA 2'h3
`endif

// *** hdl/port_pkg.sv ***
// Purpose: Types shared by the port expander design
// Assumes: Nothing
// Notes: Link states Gray coded along idle, address, write, read
package port_pkg;
   typedef enum logic [1:0] {
      CONN_GND = 2'h0,
      CONN_VDD = 2'h1,
      CONN_SCL = 2'h2,
      CONN_SDA = 2'h3
   } conn_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_ADDR = 2'h1,
      S_WR = 2'h3,
      S_RD = 2'h2
   } link_st_t;
endpackage

// *** hdl/sync_2ff.sv ***
// Purpose: Two-flop level synchroniser, one lane per bit
// Assumes: Inputs are levels or toggles from another domain
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk,              // Destination clock
   input wire logic nrst,             // Async reset, active low
   input wire logic [WIDTH-1:0] d,    // Asynchronous input
   output logic [WIDTH-1:0] q         // Synchronised output
);
   logic [WIDTH-1:0] meta_q;
   if (WIDTH < 1) begin : g_bad
      $error("sync_2ff width must be at least one");
   end
   // Two stages per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_lane
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            meta_q[i] <= 1'h0;
            q[i] <= 1'h0;
         end else begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   end
endmodule

// *** test/bus_master_model.sv ***
// Purpose: Behavioural two-wire bus master facing the port expander
// Assumes: Bus clock period 48 ns; clock stands high between frames
// Notes: Data line is open drain; the bench resolves it with a pull-up
`timescale 1ns/10ps
module bus_master_model (
   output logic scl,      // Bus clock, idles high
   output logic sda_low,  // High pulls bus data low
   input wire logic sda   // Resolved bus data level
);
   // Idle bus, both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // One bit: data set in clock low, sampled in clock high
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      #12;
      scl = 1'b1;
      #12;
      r = sda;
      #12;
      scl = 1'b0;
      #12;
   endtask
   // Start: data falls with clock high
   task automatic start;
      sda_low = 1'b1;
      #24;
      scl = 1'b0;
      #12;
   endtask
   // Stop: data rises with clock high, then clock stands still
   task automatic stop;
      sda_low = 1'b1;
      #12;
      scl = 1'b1;
      #24;
      sda_low = 1'b0;
      #24;
   endtask
   // Byte MSB first, then ninth bit; mack is what the master puts there
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(mack, r);
      ack = !r;
   endtask
endmodule

// *** test/port_expander_core_bench.sv ***
// Purpose: Self-checking bench of address decode, straps and change detect
// Assumes: Bus master model drives the link; pins resolved here
// Notes: Port levels are external level ANDed with the open-drain latch
`timescale 1ns/10ps
module port_expander_core_bench import port_pkg::*;;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic scl;
   logic m_low;
   logic sda;
   logic sda_o_q;
   logic sda_oe_n_q;
   logic alert_n_q;
   logic [7:0] oe_n;
   logic [7:0] pu;
   logic [7:0] pp;
   logic [7:0] o_q;
   logic [7:0] ext = 8'hff;
   conn_t lo_c = CONN_VDD;
   conn_t hi_c = CONN_VDD;
   int err_total = 0;
   int check_count = 0;
   // Pin level for a given address pin connection
   function automatic logic lvl(input conn_t c, input logic s, input logic d);
      case (c)
         CONN_GND: return 1'b0;
         CONN_VDD: return 1'b1;
         CONN_SCL: return s;
         default: return d;
      endcase
   endfunction
   // Wire resolution with pull-ups
   assign sda = !(m_low || !sda_oe_n_q);
   always #50 clk_sys = ~clk_sys;
   port_expander_core #(.SETTLE(3)) i_port_expander_core (
      .clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda),
      .sda_o_q(sda_o_q), .sda_oe_n_q(sda_oe_n_q),
      .addr_sel_low(lvl(lo_c, scl, sda)), .addr_sel_high(lvl(hi_c, scl, sda)),
      .bidir_ports_i(ext & oe_n), .bidir_ports_o_q(o_q), .bidir_ports_oe_n_q(oe_n),
      .pullup_en_q(pu), .pushpull_outputs_q(pp), .alert_n_q(alert_n_q)
   );
   bus_master_model i_bus_master_model (.scl(scl), .sda_low(m_low), .sda(sda));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Expected slave address from the pin connections
   function automatic logic [6:0] adr(input logic [2:0] top);
      return {top, hi_c == CONN_GND || hi_c == CONN_VDD, hi_c == CONN_VDD || hi_c == CONN_SDA, lo_c};
   endfunction
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic exp_ack);
      logic [7:0] rx;
      logic ack;
      i_bus_master_model.start();
      i_bus_master_model.xfer({a, 1'b0}, 1'b1, rx, ack);
      chk(8'(ack), 8'(exp_ack));
      chk(8'(sda_o_q), 8'h00);
      if (ack) begin
         i_bus_master_model.xfer(d, 1'b1, rx, ack);
      end
      i_bus_master_model.stop();
      cyc(6);
   endtask
   // Two-byte read, master stalls after the address acknowledge
   task automatic rd2(input logic [6:0] a, output logic [7:0] b0, output logic [7:0] b1);
      logic ack;
      i_bus_master_model.start();
      i_bus_master_model.xfer({a, 1'b1}, 1'b1, b0, ack);
      chk(8'(ack), 8'h01);
      cyc(6);
      chk(8'(alert_n_q), 8'h01);
      i_bus_master_model.xfer(8'hff, 1'b0, b0, ack);
      i_bus_master_model.xfer(8'hff, 1'b1, b1, ack);
      i_bus_master_model.stop();
      cyc(6);
   endtask
   // Power-up levels and pullups for every ground or supply strap
   task automatic t_strap;
      logic [7:0] e;
      for (int k = 0; k < 4; k++) begin
         hi_c <= k[1] ? CONN_VDD : CONN_GND;
         lo_c <= k[0] ? CONN_VDD : CONN_GND;
         e = {{4{k[1]}}, {4{k[0]}}};
         nrst <= 1'b0;
         cyc(12);
         nrst <= 1'b1;
         cyc(12);
         chk(pu, e);
         chk(pp, e);
         chk(oe_n, e);
         chk(o_q, 8'h00);
         chk(8'(alert_n_q), 8'h01);
      end
   endtask
   // All sixteen pin pairs, changed without reset, both groups
   task automatic t_addr;
      for (int k = 0; k < 16; k++) begin
         hi_c <= conn_t'(k[3:2]);
         lo_c <= conn_t'(k[1:0]);
         cyc(1);
         wr(adr(3'h5), 8'(k), 1'b1);
         chk(pp, 8'(k));
         chk(pu, {{4{hi_c != CONN_GND}}, {4{lo_c != CONN_GND}}});
         wr(adr(3'h5) ^ 7'h01, 8'h00, 1'b0);
         wr(adr(3'h6), 8'hff, 1'b1);
      end
      hi_c <= CONN_VDD;
      lo_c <= CONN_VDD;
      cyc(1);
   endtask
   // Transient on one input, sticky flag, read-back and clearing
   task automatic t_change;
      logic [7:0] b0;
      logic [7:0] b1;
      wr(adr(3'h6), 8'hff, 1'b1);
      cyc(8);
      rd2(adr(3'h6), b0, b1);
      chk(8'(alert_n_q), 8'h01);
      ext <= 8'hf7;
      cyc(6);
      chk(8'(alert_n_q), 8'h00);
      ext <= 8'hff;
      cyc(6);
      chk(8'(alert_n_q), 8'h00);
      rd2(adr(3'h6), b0, b1);
      chk(b0, 8'hff);
      chk(b1, 8'h08);
      chk(8'(alert_n_q), 8'h01);
      rd2(adr(3'h6), b0, b1);
      chk(b1, 8'h00);
   endtask
   // Port levels moved by a bus write stay quiet
   task automatic t_quiet;
      logic [7:0] b0;
      logic [7:0] b1;
      wr(adr(3'h6), 8'h5a, 1'b1);
      chk(oe_n, 8'h5a);
      cyc(10);
      chk(8'(alert_n_q), 8'h01);
      rd2(adr(3'h6), b0, b1);
      chk(b0, 8'h5a);
      chk(b1, 8'h00);
   endtask
   // Main sequence
   initial begin
      cyc(1);
      t_strap();
      t_addr();
      t_change();
      t_quiet();
      summarize();
   end
   // Watchdog, about twenty times the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      summarize();
   end
endmodule
